// *** comparator_front.sv ***
// Comparator bank and sense resistor facing the gate controller.
`timescale 1ns/10ps
`default_nettype none
module comparator_front (
  input  wire logic                            clk,    // System clock
  input  wire logic [8:0]                      vcc_dv, // Supply, tenths of a volt
  input  wire logic [6:0]                      fb_dv,  // Feedback, tenths of a volt
  input  wire logic [6:0]                      slope,  // Sense rise per clock, centivolts
  input  wire logic [1:0]                      bad,    // Frequency pin bad, sense pin open
  input  wire logic                            gate,   // Gate level at the switch
  output var  logic [pwm_guard_pkg::CMP_N-1:0] cmp     // Comparator flags
);
  import pwm_guard_pkg::*;
  logic [9:0] cs_cv;
  // The ramp exists only while the switch conducts, and it saturates so it never wraps.
  always_ff @(posedge clk) begin
    if (!gate) cs_cv <= 10'h000;
    else if (cs_cv < 10'h380) cs_cv <= cs_cv + 10'(slope);
  end
  assign cmp[C_ON]       = vcc_dv >= 9'h0a0;
  assign cmp[C_OFF]      = vcc_dv <= 9'h064;
  assign cmp[C_OVER]     = vcc_dv >= 9'h113;
  assign cmp[C_CS_PEAK]  = cs_cv >= 10'(fb_dv) * 10'h003;
  assign cmp[C_CS_MAX]   = cs_cv >= 10'h055;
  assign cmp[C_FB_OFF]   = fb_dv < 7'h0c;
  assign cmp[C_FB_OLP]   = fb_dv >= 7'h32;
  assign cmp[C_GREEN]    = fb_dv <= 7'h17;
  assign cmp[C_FSP_BAD]  = bad[0];
  assign cmp[C_CS_FLOAT] = bad[1];
endmodule : comparator_front
`default_nettype wire

// *** offline_pwm_protection_logic.sv ***
// Gate pulse generator with lockout, overload, overvoltage and pin-fault guards.
`timescale 1ns/10ps
`default_nettype none

module offline_pwm_protection_logic #(
  parameter int unsigned OLP_DELAY = pwm_guard_pkg::OLP_CYCLES // Overload delay in periods
) (
  input  wire logic                         clk,           // 10 MHz system clock
  input  wire logic                         rst_n,         // Asynchronous reset, active low
  input  wire logic [pwm_guard_pkg::CMP_N-1:0] cmp_in,     // Raw comparator flags
  output var  logic                         gate_ff,       // MOSFET gate drive
  output var  logic                         startup_source_pin_en_ff, // Startup source on
  input  wire logic [7:0]                   s_axi_awaddr,  // Write address
  input  wire logic                         s_axi_awvalid, // Write address valid
  output var  logic                         s_axi_awready, // Write address ready
  input  wire logic [31:0]                  s_axi_wdata,   // Write data
  input  wire logic [3:0]                   s_axi_wstrb,   // Write byte strobes
  input  wire logic                         s_axi_wvalid,  // Write data valid
  output var  logic                         s_axi_wready,  // Write data ready
  output var  logic [1:0]                   s_axi_bresp,   // Write response
  output var  logic                         s_axi_bvalid,  // Write response valid
  input  wire logic                         s_axi_bready,  // Write response ready
  input  wire logic [7:0]                   s_axi_araddr,  // Read address
  input  wire logic                         s_axi_arvalid, // Read address valid
  output var  logic                         s_axi_arready, // Read address ready
  output var  logic [31:0]                  s_axi_rdata,   // Read data
  output var  logic [1:0]                   s_axi_rresp,   // Read response
  output var  logic                         s_axi_rvalid,  // Read data valid
  input  wire logic                         s_axi_rready   // Read data ready
);
  import pwm_guard_pkg::*;

  // ---------------------------------------------------------------------------
  // Comparator synchronisers
  // ---------------------------------------------------------------------------
  logic [CMP_N-1:0] sync1_ff;
  logic [CMP_N-1:0] cmp_s;

  genvar gi;
  generate
    for (gi = 0; gi < CMP_N; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_ff[gi] <= 1'b0;
          cmp_s[gi]    <= 1'b0;
        end else begin
          sync1_ff[gi] <= cmp_in[gi];
          cmp_s[gi]    <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------------
  logic             enable_ff;
  logic [7:0]       rt_kohm_ff;
  logic [PER_W-1:0] period_ff;
  logic [15:0]      rt_period;
  logic [PER_W-1:0] max_on;

  // ---------------------------------------------------------------------------
  // Supply lockout and startup source
  // ---------------------------------------------------------------------------
  logic run_ff;
  logic turn_on_ev;
  logic turn_off_ev;

  assign turn_on_ev  = !run_ff && cmp_s[C_ON];
  assign turn_off_ev = run_ff && cmp_s[C_OFF] && !cmp_s[C_ON];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_ff <= 1'b0;
    end else if (turn_on_ev) begin
      run_ff <= 1'b1;
    end else if (turn_off_ev) begin
      run_ff <= 1'b0;
    end
  end

  // The source follows the lockout one cycle late; no gate pulse is possible
  // in that cycle because the gate register also follows run_ff one cycle late.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startup_source_pin_en_ff <= 1'b1;
    end else begin
      startup_source_pin_en_ff <= !run_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Oscillator
  // ---------------------------------------------------------------------------
  osc_if osc_link ();

  switching_oscillator u_osc (
    .clk   (clk),
    .rst_n (rst_n),
    .osc   (osc_link.osc)
  );

  assign rt_period = 16'(({8'h00, rt_kohm_ff} * 16'(PER_NUM)) / 16'(PER_DEN));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_ff <= PER_W'(GREEN_PER);
    end else if (cmp_s[C_GREEN]) begin
      period_ff <= PER_W'(GREEN_PER);
    end else if (rt_period < 16'(MIN_PER)) begin
      period_ff <= PER_W'(MIN_PER);
    end else if (rt_period > 16'((1 << PER_W) - 1)) begin
      period_ff <= PER_W'((1 << PER_W) - 1);
    end else begin
      period_ff <= rt_period[PER_W-1:0];
    end
  end

  assign osc_link.period = period_ff;
  assign max_on = PER_W'((32'(period_ff) * DUTY_NUM) >> DUTY_SHIFT);

  // ---------------------------------------------------------------------------
  // Overload guard
  // ---------------------------------------------------------------------------
  logic [15:0] olp_cnt_ff;
  logic        olp_latch_ff;
  logic [1:0]  div_cnt_ff;
  logic        olp_trip;

  assign olp_trip = cmp_s[C_FB_OLP] && osc_link.cycle_start
                    && olp_cnt_ff == 16'(OLP_DELAY - 1);

  // Counts oscillator periods, so the delay shrinks as the frequency rises.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      olp_cnt_ff <= '0;
    end else if (!cmp_s[C_FB_OLP] || !run_ff || olp_latch_ff) begin
      olp_cnt_ff <= '0;
    end else if (osc_link.cycle_start) begin
      olp_cnt_ff <= olp_cnt_ff + 16'h0001;
    end
  end

  // Activation wins over a release in the same cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      olp_latch_ff <= 1'b0;
      div_cnt_ff   <= '0;
    end else if (olp_trip) begin
      olp_latch_ff <= 1'b1;
      div_cnt_ff   <= '0;
    end else if (olp_latch_ff && turn_off_ev) begin
      if (div_cnt_ff == 2'(DIV_COUNT - 1)) begin
        olp_latch_ff <= 1'b0;
        div_cnt_ff   <= '0;
      end else begin
        div_cnt_ff <= div_cnt_ff + 2'b01;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Overvoltage guard
  // ---------------------------------------------------------------------------
  logic ovp_ff;

  // A fresh overvoltage wins over the turn-on that would clear the latch.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovp_ff <= 1'b0;
    end else if (cmp_s[C_OVER]) begin
      ovp_ff <= 1'b1;
    end else if (turn_on_ev) begin
      ovp_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Gate pulse
  // ---------------------------------------------------------------------------
  logic       allowed;
  logic       fault;
  logic [2:0] blank_ff;
  logic       cs_end;
  logic       nxt_gate;

  assign fault   = cmp_s[C_FSP_BAD] || cmp_s[C_CS_FLOAT];
  assign allowed = run_ff && enable_ff && !ovp_ff && !olp_latch_ff && !fault
                   && !cmp_s[C_FB_OFF] && !cmp_s[C_OVER];
  assign cs_end  = (blank_ff == '0) && (cmp_s[C_CS_PEAK] || cmp_s[C_CS_MAX]);

  always_comb begin
    nxt_gate = gate_ff;
    if (!allowed) begin
      nxt_gate = 1'b0;
    end else if (osc_link.cycle_start) begin
      nxt_gate = 1'b1;
    end else if (cs_end || osc_link.phase >= max_on) begin
      nxt_gate = 1'b0;
    end
  end

  // Reset drives the gate low so the switch is never falsely on.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_ff <= 1'b0;
    end else begin
      gate_ff <= nxt_gate;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_ff <= '0;
    end else if (nxt_gate && !gate_ff) begin
      blank_ff <= 3'(BLANK_CYC - 1);
    end else if (blank_ff != '0) begin
      blank_ff <= blank_ff - 3'b001;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  logic        aw_have_ff;
  logic        w_have_ff;
  logic [7:0]  waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        do_write;
  logic [31:0] status;
  logic [31:0] rd_mux;
  logic        rd_ok;

  assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_ff    <= 1'b0;
      waddr_ff      <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_ff    <= 1'b1;
      waddr_ff      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_have_ff <= 1'b0;
    end else if (!aw_have_ff && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_have_ff    <= 1'b0;
      wdata_ff     <= '0;
      wstrb_ff     <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_ff    <= 1'b1;
      wdata_ff     <= s_axi_wdata;
      wstrb_ff     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_have_ff <= 1'b0;
    end else if (!w_have_ff && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (waddr_ff == ADDR_CTRL || waddr_ff == ADDR_RT) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_ff  <= CTRL_RESET;
      rt_kohm_ff <= RT_RESET;
    end else if (do_write && wstrb_ff[0]) begin
      if (waddr_ff == ADDR_CTRL) begin
        enable_ff <= wdata_ff[CTRL_EN_BIT];
      end
      if (waddr_ff == ADDR_RT) begin
        rt_kohm_ff <= wdata_ff[7:0];
      end
    end
  end

  always_comb begin
    status              = '0;
    status[ST_RUN]      = run_ff;
    status[ST_STARTUP]  = startup_source_pin_en_ff;
    status[ST_GATE]     = gate_ff;
    status[ST_OLP]      = olp_latch_ff;
    status[ST_OVP]      = ovp_ff;
    status[ST_FAULT]    = fault;
    status[ST_GREEN]    = cmp_s[C_GREEN];
    status[ST_FBOFF]    = cmp_s[C_FB_OFF];
    status[ST_DIV_LO +: 2] = div_cnt_ff;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL:   rd_mux = {31'h0, enable_ff};
      ADDR_RT:     rd_mux = {24'h0, rt_kohm_ff};
      ADDR_STATUS: rd_mux = status;
      ADDR_PERIOD: rd_mux = {20'h0, period_ff};
      default: begin
        rd_mux = '0;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_source_follows_run : assert property (@(posedge clk) disable iff (!rst_n)
    !run_ff |=> startup_source_pin_en_ff) else $error("startup source off below turn-on");

  a_lockout_hysteresis : assert property (@(posedge clk) disable iff (!rst_n)
    run_ff && !cmp_s[C_OFF] |=> run_ff) else $error("lockout dropped above turn-off");

  a_max_sense_ends : assert property (@(posedge clk) disable iff (!rst_n)
    gate_ff && blank_ff == '0 && cmp_s[C_CS_MAX] && !osc_link.cycle_start |=> !gate_ff)
    else $error("pulse survived maximum current sense");

  a_blank_holds_gate : assert property (@(posedge clk) disable iff (!rst_n)
    $rose(gate_ff) && allowed |-> blank_ff == 3'(BLANK_CYC - 1))
    else $error("blanking not loaded on turn-on");

  a_duty_ceiling : assert property (@(posedge clk) disable iff (!rst_n)
    gate_ff && osc_link.phase > max_on |-> !allowed or osc_link.cycle_start or ##1 !gate_ff)
    else $error("on-time beyond duty ceiling");

  a_fb_off_stops : assert property (@(posedge clk) disable iff (!rst_n)
    cmp_s[C_FB_OFF] |=> !gate_ff) else $error("gate on during feedback shutdown");

  a_olp_latches : assert property (@(posedge clk) disable iff (!rst_n)
    olp_trip |=> olp_latch_ff ##1 !gate_ff) else $error("overload did not latch off");

  a_olp_release : assert property (@(posedge clk) disable iff (!rst_n)
    $fell(olp_latch_ff) |-> $past(turn_off_ev) && $past(div_cnt_ff) == 2'(DIV_COUNT - 1))
    else $error("overload latch released early");

  a_ovp_holds : assert property (@(posedge clk) disable iff (!rst_n)
    cmp_s[C_OVER] |=> ovp_ff && !gate_ff) else $error("gate on under overvoltage");

  a_fault_stops : assert property (@(posedge clk) disable iff (!rst_n)
    fault |=> !gate_ff) else $error("gate on with pin fault");

endmodule : offline_pwm_protection_logic
`default_nettype wire

// *** osc_if.sv ***
// Link between the gate controller and its switching oscillator.
`timescale 1ns/10ps
`default_nettype none
interface osc_if;
  import pwm_guard_pkg::*;
  logic [PER_W-1:0] period;
  logic [PER_W-1:0] phase;
  logic             cycle_start;
  modport osc (input period, output phase, output cycle_start);
  modport ctl (output period, input phase, input cycle_start);
endinterface : osc_if
`default_nettype wire

// *** pwm_guard_pkg.sv ***
// Constants shared by the flyback gate controller and its oscillator.
package pwm_guard_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned BLANK_NS     = 350;
  localparam int unsigned BLANK_CYC    = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned NOM_FREQ_HZ  = 65_000;
  localparam int unsigned GREEN_HZ     = 20_000;
  localparam int unsigned RT_REF_KOHM  = 100;
  localparam int unsigned PER_NUM      = CLK_HZ / 100_000;
  localparam int unsigned PER_DEN      = NOM_FREQ_HZ * RT_REF_KOHM / 100_000;
  localparam int unsigned GREEN_PER    = CLK_HZ / GREEN_HZ;
  localparam int unsigned OLP_MS       = 30;
  localparam int unsigned OLP_CYCLES   = OLP_MS * NOM_FREQ_HZ / 1000;
  localparam int unsigned DUTY_NUM     = 3;
  localparam int unsigned DUTY_SHIFT   = 2;
  localparam int unsigned PER_W        = 12;
  localparam int unsigned MIN_PER      = 8;
  localparam int unsigned DIV_COUNT    = 2;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RT     = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0c;

  localparam logic        CTRL_RESET = 1'b1;
  localparam logic [7:0]  RT_RESET   = 8'h64;
  localparam int unsigned CTRL_EN_BIT = 0;

  localparam int unsigned ST_RUN     = 0;
  localparam int unsigned ST_STARTUP = 1;
  localparam int unsigned ST_GATE    = 2;
  localparam int unsigned ST_OLP     = 3;
  localparam int unsigned ST_OVP     = 4;
  localparam int unsigned ST_FAULT   = 5;
  localparam int unsigned ST_GREEN   = 6;
  localparam int unsigned ST_FBOFF   = 7;
  localparam int unsigned ST_DIV_LO  = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------------------
  // Comparator input positions
  // ---------------------------------------------------------------------------
  localparam int unsigned CMP_N      = 10;
  localparam int unsigned C_ON       = 0;
  localparam int unsigned C_OFF      = 1;
  localparam int unsigned C_OVER     = 2;
  localparam int unsigned C_CS_PEAK  = 3;
  localparam int unsigned C_CS_MAX   = 4;
  localparam int unsigned C_FB_OFF   = 5;
  localparam int unsigned C_FB_OLP   = 6;
  localparam int unsigned C_GREEN    = 7;
  localparam int unsigned C_FSP_BAD  = 8;
  localparam int unsigned C_CS_FLOAT = 9;

endpackage : pwm_guard_pkg

// *** switching_oscillator.sv ***
// Oscillator with its period set by osc.period: phase counter with a start pulse per period.
`timescale 1ns/10ps
`default_nettype none
module switching_oscillator (
  input  wire logic clk,   // System clock
  input  wire logic rst_n, // Asynchronous reset, active low
  osc_if.osc        osc    // Period in, phase and cycle start out
);
  import pwm_guard_pkg::*;

  logic [PER_W-1:0] phase_ff;
  logic             start_ff;

  // A period change takes effect at once: a cycle past the new period wraps next clock, a longer period stretches it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= '0;
      start_ff <= 1'b0;
    end else if (phase_ff >= osc.period - PER_W'(1)) begin
      phase_ff <= '0;
      start_ff <= 1'b1;
    end else begin
      phase_ff <= phase_ff + PER_W'(1);
      start_ff <= 1'b0;
    end
  end

  assign osc.phase       = phase_ff;
  assign osc.cycle_start = start_ff;

  a_osc_wrap : assert property (@(posedge clk) disable iff (!rst_n)
    start_ff |-> phase_ff == '0) else $error("cycle start away from phase zero");

endmodule : switching_oscillator
`default_nettype wire

// *** test_offline_pwm_protection_logic.sv ***
// Self-checking bench for the flyback gate controller.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, g, e); \
  end \
end
module test_offline_pwm_protection_logic;
  import pwm_guard_pkg::*;
  typedef struct {logic [6:0] fb; logic [6:0] sl; int lo; int hi;} row_t;
  // Feedback and sense slope against the on-time range at a 184 clock period.
  row_t        rows [4] = '{'{7'h28, 7'h00, 133, 138}, '{7'h28, 7'h01, 86, 91},
                            '{7'h19, 7'h01, 76, 81}, '{7'h28, 7'h3c, 4, 7}};
  logic        clk = 1'b0, rst_n = 1'b0, gate, src_en;
  logic [9:0]  cmp;
  logic [8:0]  vcc = 9'h000;
  logic [6:0]  fb = 7'h28, sl = 7'h00;
  logic [1:0]  bad = 2'b00, bresp, rresp, rs;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  int          num_errors = 0, total_checks = 0, cyc = 0, hi, per, h;
  comparator_front front (.clk(clk), .vcc_dv(vcc), .fb_dv(fb), .slope(sl), .bad(bad),
                          .gate(gate), .cmp(cmp));
  // A four-period overload delay keeps the run short.
  offline_pwm_protection_logic #(.OLP_DELAY(4)) dut (
    .clk(clk), .rst_n(rst_n), .cmp_in(cmp), .gate_ff(gate), .startup_source_pin_en_ff(src_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // Waits for a fresh rising gate, then counts its high and total cycles.
  task automatic measure();
    while (gate === 1'b1) @(negedge clk);
    while (gate !== 1'b1) @(negedge clk);
    hi = 0;
    while (gate === 1'b1) begin
      @(negedge clk);
      hi++;
    end
    per = hi;
    while (gate !== 1'b1) begin
      @(negedge clk);
      per++;
    end
  endtask : measure
  task automatic quiet(input int n);
    h = 0;
    repeat (n) begin
      @(negedge clk);
      h += int'(gate !== 1'b0);
    end
  endtask : quiet
  task automatic supply(input logic [8:0] v);
    @(posedge clk);
    vcc <= v;
    repeat (10) @(negedge clk);
  endtask : supply
  task automatic apply(input int k, input logic on);
    @(posedge clk);
    case (k)
      0: fb <= on ? 7'h0a : 7'h28;
      1: vcc <= on ? 9'h118 : 9'h0a5;
      default: bad[k-2] <= on;
    endcase
  endtask : apply
  task automatic stop_check(input int k);
    measure();
    apply(k, 1'b1);
    repeat (5) @(negedge clk);
    `CHK(gate, 1'b0)
    quiet(400);
    `CHK(h, 0)
  endtask : stop_check
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    quiet(50);
    `CHK(h, 0)
    `CHK(src_en, 1'b1)
    axi_rd(ADDR_CTRL);
    `CHK(rd[0], CTRL_RESET)
    axi_rd(ADDR_PERIOD);
    `CHK(rd, 32'h99)
    supply(9'h0a5);
    `CHK(src_en, 1'b0)
    measure();
    `CHK(per, 153)
    `CHK(hi inside {[110:115]}, 1'b1)
    axi_wr(ADDR_RT, 32'h78);
    axi_rd(ADDR_PERIOD);
    `CHK(rd, 32'hb8)
    axi_wr(8'h10, 32'h0);
    `CHK(rs, RESP_SLVERR)
    axi_rd(8'h10);
    `CHK({rs, rd}, {RESP_SLVERR, 32'h0})
    foreach (rows[i]) begin
      fb <= rows[i].fb;
      sl <= rows[i].sl;
      measure();
      `CHK(hi inside {[rows[i].lo:rows[i].hi]}, 1'b1)
    end
    fb <= 7'h14;
    sl <= 7'h00;
    repeat (10) @(negedge clk);
    axi_rd(ADDR_PERIOD);
    `CHK(rd, 32'h1f4)
    fb <= 7'h28;
    supply(9'h078);
    measure();
    `CHK(hi inside {[133:138]}, 1'b1)
    supply(9'h05a);
    `CHK(src_en, 1'b1)
    quiet(200);
    `CHK(h, 0)
    supply(9'h0a5);
    stop_check(0);
    apply(0, 1'b0);
    measure();
    `CHK(hi inside {[133:138]}, 1'b1)
    stop_check(1);
    apply(1, 1'b0);
    quiet(400);
    `CHK(h, 0)
    supply(9'h05a);
    supply(9'h0a5);
    measure();
    `CHK(hi inside {[133:138]}, 1'b1)
    fb <= 7'h3c;
    measure();
    measure();
    `CHK(hi inside {[133:138]}, 1'b1)
    repeat (1500) @(negedge clk);
    quiet(400);
    `CHK(h, 0)
    supply(9'h05a);
    supply(9'h0a5);
    quiet(400);
    `CHK(h, 0)
    axi_rd(ADDR_STATUS);
    `CHK({rd[ST_DIV_LO +: 2], rd[ST_OLP]}, 3'b011)
    fb <= 7'h28;
    supply(9'h05a);
    supply(9'h0a5);
    measure();
    `CHK(hi inside {[133:138]}, 1'b1)
    stop_check(2);
    apply(2, 1'b0);
    supply(9'h05a);
    supply(9'h0a5);
    stop_check(3);
    end_of_test();
  end
endmodule : test_offline_pwm_protection_logic
`default_nettype wire
